// ---- pldc_pkg.sv ----
`default_nettype none
package pldc_pkg;
	// datapath geometry
	localparam int DW = 8;
	localparam int NCFG = 8;
	localparam int CFGW = 16;
	localparam int NCOND = 16;
	localparam int NROUTE = 6;
	localparam int QDEPTH_DEF = 4;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [2:0] TOP_BIT = 3'h7;

	// bus addresses of the working registers, queues and configuration words
	localparam logic [4:0] ADDR_ACC0 = 5'h00;
	localparam logic [4:0] ADDR_ACC1 = 5'h01;
	localparam logic [4:0] ADDR_OPR0 = 5'h02;
	localparam logic [4:0] ADDR_OPR1 = 5'h03;
	localparam logic [4:0] ADDR_QUE0 = 5'h04;
	localparam logic [4:0] ADDR_QUE1 = 5'h05;
	localparam logic ADDR_CFG_FLAG = 1'h1;

	// alu operations
	localparam logic [2:0] OP_INC = 3'h0;
	localparam logic [2:0] OP_DEC = 3'h1;
	localparam logic [2:0] OP_ADD = 3'h2;
	localparam logic [2:0] OP_SUB = 3'h3;
	localparam logic [2:0] OP_AND = 3'h4;
	localparam logic [2:0] OP_OR = 3'h5;
	localparam logic [2:0] OP_XOR = 3'h6;
	localparam logic [2:0] OP_PASS = 3'h7;

	// shifter, sources, destinations, carry and serial selects
	localparam logic [1:0] SH_NONE = 2'h0;
	localparam logic [1:0] SH_LEFT = 2'h1;
	localparam logic [1:0] SH_RIGHT = 2'h2;
	localparam logic [1:0] SH_SWAP = 2'h3;
	localparam logic [1:0] SRC_A0 = 2'h0;
	localparam logic [1:0] SRC_A1 = 2'h1;
	localparam logic [1:0] SRC_D0 = 2'h2;
	localparam logic [1:0] DST_A0 = 2'h1;
	localparam logic [1:0] DST_A1 = 2'h2;
	localparam logic [1:0] DST_BOTH = 2'h3;
	localparam logic [1:0] CIN_ZERO = 2'h0;
	localparam logic [1:0] CIN_ROUTE = 2'h1;
	localparam logic [1:0] CIN_CHAIN = 2'h2;
	localparam logic [1:0] SI_ROUTE = 2'h0;
	localparam logic [1:0] SI_CHAIN = 2'h1;
	localparam logic [1:0] SI_SAVED = 2'h2;

	// configuration word fields
	localparam int F_OP = 0;
	localparam int F_ASEL = 3;
	localparam int F_BSEL = 5;
	localparam int F_SH = 7;
	localparam int F_MASK = 9;
	localparam int F_DST = 10;
	localparam int F_Q0 = 12;
	localparam int F_Q1 = 13;
	localparam int F_CIN = 14;

	// routing input bits
	localparam int RI_ADDR = 0;
	localparam int RI_SIN = 3;
	localparam int RI_CIN = 4;
	localparam int RI_RUN = 5;

	// condition indices
	localparam int C_EQ0 = 0;
	localparam int C_LT0 = 1;
	localparam int C_EQ1 = 2;
	localparam int C_LT1 = 3;
	localparam int C_Z0 = 4;
	localparam int C_Z1 = 5;
	localparam int C_FF0 = 6;
	localparam int C_FF1 = 7;
	localparam int C_OV = 8;
	localparam int C_CO = 9;
	localparam int C_SO = 10;
	localparam int C_Q0E = 11;
	localparam int C_Q0F = 12;
	localparam int C_Q1E = 13;
	localparam int C_Q1F = 14;
	localparam int C_CHEQ = 15;
endpackage
`default_nettype wire

// ---- pldc_top.sv ----
`timescale 1ns/10ps
`default_nettype none

// sum-of-products array with per-output register bypass
module pldc_pt_array #(
	parameter int NIN  = 12,
	parameter int NPT  = 8,
	parameter int NOUT = 4
) (
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic [NIN-1:0]      pin,
	input  wire logic [NPT*NIN-1:0]  t_sel,
	input  wire logic [NPT*NIN-1:0]  c_sel,
	input  wire logic [NOUT*NPT-1:0] or_sel,
	input  wire logic [NOUT-1:0]     reg_sel,
	output logic      [NOUT-1:0]     pout
);
	logic [NPT-1:0]  pt;
	logic [NOUT-1:0] sop;
	logic [NOUT-1:0] sop_reg;

	if (NIN < 1 || NPT < 1 || NOUT < 1) begin : g_chk
		$error("term array sizes must be positive");
	end

	// product terms: an unselected input contributes a one
	for (genvar p = 0; p < NPT; p++) begin : g_pt
		assign pt[p] = &((pin | ~t_sel[p*NIN +: NIN]) & (~pin | ~c_sel[p*NIN +: NIN]));
	end

	// fixed-width or plane
	for (genvar o = 0; o < NOUT; o++) begin : g_or
		assign sop[o] = |(pt & or_sel[o*NPT +: NPT]);
	end

	// registered copy of every sum
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sop_reg <= '0;
		end else begin
			sop_reg <= sop;
		end
	end

	assign pout = (reg_sel & sop_reg) | (~reg_sel & sop);

	a_pld_reg_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$stable(reg_sel) && $past(rst_n) |-> ((pout & reg_sel) == ($past(sop) & reg_sel)))
		else $error("registered sum does not follow previous term value");
endmodule

// byte queue with honest full and empty
module pldc_qfifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data,
	output logic              full,
	output logic              empty
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW-1:0] LAST = AW'(D - 1);
	localparam logic [AW:0] CNT_FULL = (AW + 1)'(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   cnt_reg;
	logic          push;
	logic          pop;

	if (D < 2 || W < 1) begin : g_chk
		$error("queue needs depth of two or more");
	end

	// overrun and underrun are simply not taken
	assign full = (cnt_reg == CNT_FULL);
	assign empty = (cnt_reg == '0);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign push = in_valid & ~full;
	assign pop = out_ready & ~empty;
	assign out_data = mem[rd_reg];

	// storage
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
			if (pop) rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	a_full_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		full && in_valid && !out_ready |=> full && $stable(wr_reg))
		else $error("write into full queue changed it");
	a_empty_no_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		empty && out_ready && !in_valid |=> empty && $stable(rd_reg))
		else $error("read from empty queue moved it");
endmodule

// one programmable cell: two term arrays plus the 8-bit datapath
module pldc_top
	import pldc_pkg::*;
#(
	parameter int QDEPTH = QDEPTH_DEF
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [4:0]        bus_addr,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	input  wire logic [DW-1:0]     bus_wdata,
	output logic      [DW-1:0]     bus_rdata,
	output logic                   bus_rvalid,
	output logic      [1:0]        q_wr_ready,
	input  wire logic [11:0]       pld0_in,
	input  wire logic [95:0]       pld0_t,
	input  wire logic [95:0]       pld0_c,
	input  wire logic [31:0]       pld0_or,
	input  wire logic [3:0]        pld0_reg,
	output logic      [3:0]        pld0_out,
	input  wire logic [11:0]       pld1_in,
	input  wire logic [95:0]       pld1_t,
	input  wire logic [95:0]       pld1_c,
	input  wire logic [31:0]       pld1_or,
	input  wire logic [3:0]        pld1_reg,
	output logic      [3:0]        pld1_out,
	input  wire logic [NROUTE-1:0] route_in,
	output logic      [NROUTE-1:0] route_out,
	input  wire logic [4*NROUTE-1:0] out_sel,
	input  wire logic [1:0]        q_dir,
	input  wire logic [1:0]        q_acc_sel,
	input  wire logic [2:0]        msb_sel,
	input  wire logic [DW-1:0]     or_mask,
	input  wire logic              crc_en,
	input  wire logic [1:0]        si_sel,
	input  wire logic [DW-1:0]     cmp_mask0,
	input  wire logic [DW-1:0]     cmp_mask1,
	input  wire logic [1:0]        cmp_b_sel,
	input  wire logic              chain_ci,
	input  wire logic              chain_si,
	input  wire logic              chain_eq_in,
	output logic                   chain_co,
	output logic                   chain_so,
	output logic                   chain_eq_out
);
	logic [DW-1:0]   acc0_reg, acc1_reg, opr0_reg, opr1_reg;
	logic [DW-1:0]   acc0_next, acc1_next, opr0_next, opr1_next;
	logic [DW-1:0]   rdata_reg, rdata_next;
	logic            rvalid_reg, carry_reg, shift_reg;
	logic [CFGW-1:0] cfg_ram [NCFG];
	logic [CFGW-1:0] cfg;
	logic [2:0]      op;
	logic [1:0]      shm, dst, cin_sel;
	logic            run, arith, co, so, ov, cin, si, fb;
	logic [DW-1:0]   a_op, b_op, msk, am, bm, addend, logic_r, alu_raw;
	logic [DW:0]     sum9;
	logic [DW-1:0]   shifted, result;
	logic [NCOND-1:0] cond;
	logic [1:0]      q_in_v, q_in_r, q_out_v, q_out_r, q_full, q_empty;
	logic [DW-1:0]   q_in_d [2];
	logic [DW-1:0]   q_out_d [2];
	logic [1:0]      q_step, q_load;
	logic            wr_a0, wr_a1, wr_d0, wr_d1, cfg_hit;

	if (QDEPTH < 2) begin : g_chk
		$error("queue depth must be two or more");
	end

	// two independent term arrays beside the datapath
	pldc_pt_array u_pld0 (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     (pld0_in),
		.t_sel   (pld0_t),
		.c_sel   (pld0_c),
		.or_sel  (pld0_or),
		.reg_sel (pld0_reg),
		.pout    (pld0_out)
	);
	pldc_pt_array u_pld1 (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     (pld1_in),
		.t_sel   (pld1_t),
		.c_sel   (pld1_c),
		.or_sel  (pld1_or),
		.reg_sel (pld1_reg),
		.pout    (pld1_out)
	);

	// per-cycle function word picked by the routed address
	assign cfg = cfg_ram[route_in[RI_ADDR +: 3]];
	assign run = route_in[RI_RUN];
	assign op = cfg[F_OP +: 3];
	assign shm = cfg[F_SH +: 2];
	assign dst = cfg[F_DST +: 2];
	assign cin_sel = cfg[F_CIN +: 2];

	// operand selection over all four source registers
	assign a_op = (cfg[F_ASEL +: 2] == SRC_A0) ? acc0_reg :
		(cfg[F_ASEL +: 2] == SRC_A1) ? acc1_reg :
		(cfg[F_ASEL +: 2] == SRC_D0) ? opr0_reg : opr1_reg;
	assign b_op = (cfg[F_BSEL +: 2] == SRC_A0) ? acc0_reg :
		(cfg[F_BSEL +: 2] == SRC_A1) ? acc1_reg :
		(cfg[F_BSEL +: 2] == SRC_D0) ? opr0_reg : opr1_reg;

	// width limit below the programmed top bit
	assign msk = ALL_ONES >> (TOP_BIT - msb_sel);
	assign am = a_op & msk;
	assign bm = b_op & msk;

	// carry-in choice, including the saved carry
	assign cin = (cin_sel == CIN_ZERO) ? ((op == OP_INC) || (op == OP_SUB)) :
		(cin_sel == CIN_ROUTE) ? route_in[RI_CIN] :
		(cin_sel == CIN_CHAIN) ? chain_ci : carry_reg;

	// arithmetic and logic unit
	assign arith = (op == OP_INC) || (op == OP_DEC) || (op == OP_ADD) || (op == OP_SUB);
	assign addend = (op == OP_DEC) ? msk : (op == OP_ADD) ? bm :
		(op == OP_SUB) ? (~bm & msk) : RST_BYTE;
	assign sum9 = {1'b0, am} + {1'b0, addend} + {{DW{1'b0}}, cin};
	assign logic_r = (op == OP_AND) ? (am & bm) : (op == OP_OR) ? (am | bm) :
		(op == OP_XOR) ? (am ^ bm) : am;
	assign alu_raw = arith ? (sum9[DW-1:0] & msk) : logic_r;
	assign co = arith & sum9[{1'b0, msb_sel} + 4'h1];
	assign ov = arith & (am[msb_sel] ^ alu_raw[msb_sel])
		& (addend[msb_sel] ^ alu_raw[msb_sel]);

	// serial input choice, including the saved shift bit
	assign si = (si_sel == SI_ROUTE) ? route_in[RI_SIN] :
		(si_sel == SI_CHAIN) ? chain_si :
		(si_sel == SI_SAVED) ? shift_reg : 1'b0;

	// shifter with crc feedback; polynomial comes from the b operand
	assign fb = alu_raw[msb_sel] ^ si;
	assign shifted = (shm == SH_LEFT) ? (crc_en ?
			(((alu_raw << 1) & msk) ^ (fb ? bm : RST_BYTE)) :
			(((alu_raw << 1) | {{(DW-1){1'b0}}, si}) & msk)) :
		(shm == SH_RIGHT) ? ((alu_raw >> 1) | ({{(DW-1){1'b0}}, si} << msb_sel)) :
		(shm == SH_SWAP) ? {alu_raw[3:0], alu_raw[7:4]} : alu_raw;
	assign so = (shm == SH_LEFT) ? alu_raw[msb_sel] :
		(shm == SH_RIGHT) ? alu_raw[0] : 1'b0;
	assign result = cfg[F_MASK] ? (shifted | or_mask) : shifted;

	// chain outputs to the neighbouring datapath
	assign chain_co = co;
	assign chain_so = so;
	assign chain_eq_out = cond[C_EQ0];

	// masked compares and detectors
	assign cond[C_EQ0] = ((acc0_reg ^ (cmp_b_sel[0] ? acc1_reg : opr0_reg)) & cmp_mask0) == '0;
	assign cond[C_LT0] = (acc0_reg & cmp_mask0)
		< ((cmp_b_sel[0] ? acc1_reg : opr0_reg) & cmp_mask0);
	assign cond[C_EQ1] = ((acc1_reg ^ (cmp_b_sel[1] ? acc0_reg : opr1_reg)) & cmp_mask1) == '0;
	assign cond[C_LT1] = (acc1_reg & cmp_mask1)
		< ((cmp_b_sel[1] ? acc0_reg : opr1_reg) & cmp_mask1);
	assign cond[C_Z0] = (acc0_reg == RST_BYTE);
	assign cond[C_Z1] = (acc1_reg == RST_BYTE);
	assign cond[C_FF0] = (acc0_reg == ALL_ONES);
	assign cond[C_FF1] = (acc1_reg == ALL_ONES);
	assign cond[C_OV] = ov;
	assign cond[C_CO] = co;
	assign cond[C_SO] = so;
	assign cond[C_Q0E] = q_empty[0];
	assign cond[C_Q0F] = q_full[0];
	assign cond[C_Q1E] = q_empty[1];
	assign cond[C_Q1F] = q_full[1];
	assign cond[C_CHEQ] = cond[C_EQ0] & chain_eq_in;

	// six routed outputs, each a chosen condition
	for (genvar k = 0; k < NROUTE; k++) begin : g_rout
		assign route_out[k] = cond[out_sel[4*k +: 4]];
	end

	// queue hookup: bus fills input queues, datapath fills output queues
	for (genvar q = 0; q < 2; q++) begin : g_q
		assign q_step[q] = run & cfg[F_Q0 + q];
		assign q_in_v[q] = q_dir[q] ? q_step[q] : (bus_wr && bus_addr == ADDR_QUE0 + 5'(q));
		assign q_in_d[q] = q_dir[q] ? (q_acc_sel[q] ? (q ? acc1_reg : acc0_reg) : result)
			: bus_wdata;
		assign q_out_r[q] = q_dir[q] ? (bus_rd && bus_addr == ADDR_QUE0 + 5'(q)) : q_step[q];
		assign q_load[q] = ~q_dir[q] & q_step[q] & q_out_v[q];
		pldc_qfifo #(.W(DW), .D(QDEPTH)) u_q (
			.ref_clk   (ref_clk),
			.rst_n     (rst_n),
			.in_valid  (q_in_v[q]),
			.in_ready  (q_in_r[q]),
			.in_data   (q_in_d[q]),
			.out_valid (q_out_v[q]),
			.out_ready (q_out_r[q]),
			.out_data  (q_out_d[q]),
			.full      (q_full[q]),
			.empty     (q_empty[q])
		);
	end
	assign q_wr_ready = q_in_r & ~q_dir;

	// register write decode: bus first, then queue load, then alu result
	assign wr_a0 = run & dst[0];
	assign wr_a1 = run & dst[1];
	assign acc0_next = (bus_wr && bus_addr == ADDR_ACC0) ? bus_wdata :
		(q_load[0] && q_acc_sel[0]) ? q_out_d[0] :
		wr_a0 ? result : acc0_reg;
	assign acc1_next = (bus_wr && bus_addr == ADDR_ACC1) ? bus_wdata :
		(q_load[1] && q_acc_sel[1]) ? q_out_d[1] :
		wr_a1 ? result : acc1_reg;
	assign wr_d0 = q_load[0] & ~q_acc_sel[0];
	assign wr_d1 = q_load[1] & ~q_acc_sel[1];
	assign opr0_next = (bus_wr && bus_addr == ADDR_OPR0) ? bus_wdata :
		wr_d0 ? q_out_d[0] : opr0_reg;
	assign opr1_next = (bus_wr && bus_addr == ADDR_OPR1) ? bus_wdata :
		wr_d1 ? q_out_d[1] : opr1_reg;

	// bus read mux; unmapped and wrong-direction reads return zero
	assign cfg_hit = (bus_addr[4] == ADDR_CFG_FLAG);
	assign rdata_next = cfg_hit ? (bus_addr[0] ? cfg_ram[bus_addr[3:1]][15:8]
			: cfg_ram[bus_addr[3:1]][7:0]) :
		(bus_addr == ADDR_ACC0) ? acc0_reg : (bus_addr == ADDR_ACC1) ? acc1_reg :
		(bus_addr == ADDR_OPR0) ? opr0_reg : (bus_addr == ADDR_OPR1) ? opr1_reg :
		(bus_addr == ADDR_QUE0 && q_dir[0]) ? q_out_d[0] :
		(bus_addr == ADDR_QUE1 && q_dir[1]) ? q_out_d[1] : RST_BYTE;

	// working registers and saved carry and shift bits
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc0_reg <= RST_BYTE;
			acc1_reg <= RST_BYTE;
			opr0_reg <= RST_BYTE;
			opr1_reg <= RST_BYTE;
			carry_reg <= 1'b0;
			shift_reg <= 1'b0;
		end else begin
			acc0_reg <= acc0_next;
			acc1_reg <= acc1_next;
			opr0_reg <= opr0_next;
			opr1_reg <= opr1_next;
			if (run) carry_reg <= co;
			if (run) shift_reg <= so;
		end
	end

	// read data register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= RST_BYTE;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= bus_rd;
			if (bus_rd) rdata_reg <= rdata_next;
		end
	end
	assign bus_rdata = rdata_reg;
	assign bus_rvalid = rvalid_reg;

	// configuration memory, written a byte at a time
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NCFG; i++) cfg_ram[i] <= '0;
		end else if (bus_wr && cfg_hit) begin
			if (bus_addr[0]) cfg_ram[bus_addr[3:1]][15:8] <= bus_wdata;
			else cfg_ram[bus_addr[3:1]][7:0] <= bus_wdata;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_inc_a0;
		run && op == OP_INC && dst == DST_A0 && cfg[F_ASEL +: 2] == SRC_A0
		&& shm == SH_NONE && !cfg[F_MASK] && msb_sel == TOP_BIT
		&& cin_sel == CIN_ZERO && !bus_wr && !q_load[0];
	endsequence

	a_inc_step: assert property (s_inc_a0 |=> acc0_reg == $past(acc0_reg) + 8'h01)
		else $error("increment did not advance accumulator by one");
	a_carry_saved: assert property (run |=> carry_reg == $past(co))
		else $error("carry out not saved");
	a_bus_read_lat: assert property (bus_rd |=> bus_rvalid ##1 (bus_rvalid == $past(bus_rd)))
		else $error("read answer not one cycle after request");
	a_cfg_readback: assert property (bus_wr && cfg_hit ##1 !bus_wr
		##1 bus_rd && bus_addr == $past(bus_addr, 2)
		|=> bus_rdata == $past(bus_wdata, 3))
		else $error("configuration byte did not read back");
	a_out_queue_push: assert property (q_dir[1] && q_step[1] && !q_full[1] |=> !q_empty[1])
		else $error("output queue capture lost");
	a_swap_nibble: assert property (run && shm == SH_SWAP && dst == DST_BOTH
		&& !cfg[F_MASK] && !bus_wr && q_load == 2'h0 && op == OP_PASS
		|=> acc1_reg == {$past(am[3:0]), $past(am[7:4])})
		else $error("nibble swap result wrong");
endmodule
`default_nettype wire

// ---- pldc_route_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// routing matrix: presents the cycle's word address, run, serial and carry bits
module pldc_route_model
	import pldc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [2:0]        word,
	input  wire logic              go,
	input  wire logic              sin,
	input  wire logic              cin,
	output var  logic [NROUTE-1:0] route_in
);
	// changes just after the edge, one request per cycle
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) route_in <= '0;
		else route_in <= #1 {go, cin, sin, word};
	end
endmodule
`default_nettype wire

// ---- test_programmable_logic_datapath_cell.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_programmable_logic_datapath_cell import pldc_pkg::*;;
	logic        ref_clk, rst_n, bus_wr, bus_rd, bus_rvalid, crc_en;
	logic        chain_ci, chain_si, chain_eq_in, chain_co, chain_so, chain_eq_out;
	logic        rm_go, rm_sin, rm_cin;
	logic [4:0]  bus_addr;
	logic [7:0]  bus_wdata, bus_rdata, or_mask, cmp_mask0, cmp_mask1, rv, a, d;
	logic [1:0]  q_dir, q_acc_sel, si_sel, cmp_b_sel, q_wr_ready;
	logic [2:0]  msb_sel, rm_word;
	logic [3:0]  pld0_out, pld1_out;
	logic [5:0]  route_in, route_out;
	logic [11:0] pin;
	logic [95:0] tsel, csel;
	logic [31:0] por;
	logic [23:0] out_sel;
	logic [7:0]  qv[4];
	logic [15:0] cw;
	logic [8:0]  s9;
	int          n_errors, checks_done, k, n;

	pldc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
		.q_wr_ready(q_wr_ready), .pld0_in(pin), .pld0_t(tsel), .pld0_c(csel), .pld0_or(por),
		.pld0_reg(4'h0), .pld0_out(pld0_out), .pld1_in(pin), .pld1_t(tsel), .pld1_c(csel),
		.pld1_or(por), .pld1_reg(4'hF), .pld1_out(pld1_out), .route_in(route_in),
		.route_out(route_out), .out_sel(out_sel), .q_dir(q_dir), .q_acc_sel(q_acc_sel),
		.msb_sel(msb_sel), .or_mask(or_mask), .crc_en(crc_en), .si_sel(si_sel),
		.cmp_mask0(cmp_mask0), .cmp_mask1(cmp_mask1), .cmp_b_sel(cmp_b_sel),
		.chain_ci(chain_ci), .chain_si(chain_si), .chain_eq_in(chain_eq_in),
		.chain_co(chain_co), .chain_so(chain_so), .chain_eq_out(chain_eq_out));
	pldc_route_model rm_u (.ref_clk(ref_clk), .rst_n(rst_n), .word(rm_word), .go(rm_go),
		.sin(rm_sin), .cin(rm_cin), .route_in(route_in));

	// routed conditions: eq0, a0 zero, a0 ones, q0 empty, q0 full, chained eq
	assign out_sel = {4'(C_CHEQ), 4'(C_Q0F), 4'(C_Q0E), 4'(C_FF0), 4'(C_Z0), 4'(C_EQ0)};

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			n_errors++;
		end
	endtask

	// one write, then an idle edge before the strobe may rise again
	task automatic wr(input logic [4:0] ad, input logic [7:0] dt);
		bus_addr = ad;
		bus_wdata = dt;
		bus_wr = 1'b1;
		@(posedge ref_clk);
		#1 bus_wr = 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic rd(input logic [4:0] ad);
		int i;
		bus_addr = ad;
		bus_rd = 1'b1;
		@(posedge ref_clk);
		#1 bus_rd = 1'b0;
		for (i = 0; i < 4 && bus_rvalid !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 4) begin
			chk("rvalid", 8'h01, 8'h00);
			end_sim();
		end
		rv = bus_rdata;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic cfg(input logic [2:0] w, input logic [15:0] v);
		wr(5'h10 + 5'(2 * w), v[7:0]);
		wr(5'h11 + 5'(2 * w), v[15:8]);
	endtask

	// execute one word: partner holds run high for a single cycle
	task automatic run(input logic [2:0] w);
		rm_word = w;
		rm_go = 1'b1;
		rm_sin = 1'($urandom);
		@(posedge ref_clk);
		#1 rm_go = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	function automatic logic [15:0] mk(logic [2:0] op, logic [1:0] sh, logic m,
		logic [1:0] dst, logic [1:0] q);
		return {2'h0, q, dst, m, sh, SRC_D0, SRC_A0, op};
	endfunction

	function automatic logic [7:0] alu(logic [2:0] op, logic [7:0] x, logic [7:0] y);
		case (op)
			OP_INC: return x + 8'h01;
			OP_DEC: return x - 8'h01;
			OP_ADD: return x + y;
			OP_SUB: return x - y;
			OP_AND: return x & y;
			OP_OR: return x | y;
			OP_XOR: return x ^ y;
			default: return x;
		endcase
	endfunction

	function automatic logic [7:0] shx(int s, logic [7:0] x);
		case (s)
			0: return x | or_mask;
			1: return {x[6:0], 1'b0};
			2: return {1'b0, x[7:1]};
			default: return {x[3:0], x[7:4]};
		endcase
	endfunction

	// one crc step below a programmed top bit, serial input zero
	function automatic logic [7:0] crc(logic [7:0] x, logic [7:0] p, logic [2:0] m);
		logic [7:0] wm;
		wm = 8'hFF >> (3'h7 - m);
		x = x & wm;
		return ((x << 1) & wm) ^ (x[m] ? (p & wm) : 8'h00);
	endfunction

	// main sequence
	initial begin
		rst_n = 1'b0;
		{bus_wr, bus_rd, bus_addr, bus_wdata, rm_go, rm_sin, rm_cin, rm_word} = '0;
		{crc_en, cmp_b_sel, q_dir, q_acc_sel, tsel, csel, pin} = '0;
		si_sel = 2'h3;
		msb_sel = TOP_BIT;
		void'($urandom(5540));
		{or_mask, cmp_mask0, cmp_mask1} = 24'($urandom);
		{chain_ci, chain_si, chain_eq_in} = 3'($urandom);
		por = {24'($urandom), 8'h01};
		repeat (4) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (k = 0; k < 4; k++) begin
			rd(5'(k));
			chk("reset reg", RST_BYTE, rv);
		end
		chk("q0 empty", 8'h01, 8'(route_out[3]));
		for (k = 0; k < 4; k++) begin
			a = 8'($urandom);
			wr(5'(k), a);
			rd(5'(k));
			chk("reg rw", a, rv);
		end
		for (k = 0; k < 8; k++) begin
			a = (k == 0) ? ALL_ONES : 8'($urandom);
			d = (k == 3) ? a : 8'($urandom);
			cw = mk(3'(k), SH_NONE, 1'b0, DST_A0, 2'h0);
			cfg(3'(k), cw);
			rd(5'h11 + 5'(2 * k));
			chk("cfg rb", cw[15:8], rv);
			wr(ADDR_ACC0, a);
			wr(ADDR_OPR0, d);
			run(3'(k));
			rd(ADDR_ACC0);
			chk("alu", alu(3'(k), a, d), rv);
		end
		// 16-bit add over two cycles through the saved carry
		a = 8'($urandom) | 8'h01;
		cfg(3'h3, mk(OP_ADD, SH_NONE, 1'b0, DST_A0, 2'h0));
		cfg(3'h4, mk(OP_ADD, SH_NONE, 1'b0, DST_A0, 2'h0) | 16'hC000);
		wr(ADDR_ACC0, a);
		wr(ADDR_OPR0, ALL_ONES);
		run(3'h3);
		rd(ADDR_ACC0);
		chk("add lo", a - 8'h01, rv);
		a = 8'($urandom);
		d = 8'($urandom);
		wr(ADDR_ACC0, a);
		wr(ADDR_OPR0, d);
		run(3'h4);
		rd(ADDR_ACC0);
		s9 = {1'b0, a} + {1'b0, d} + 9'h001;
		chk("add hi", s9[7:0], rv);
		s9 = {1'b0, s9[7:0]} + {1'b0, d} + {8'h00, s9[8]};
		chk("chain co", 8'(s9[8]), 8'(chain_co));
		for (k = 0; k < 4; k++) begin
			a = 8'($urandom);
			cfg(3'h5, mk(OP_PASS, 2'(k), k == 0, DST_BOTH, 2'h0));
			wr(ADDR_ACC0, a);
			run(3'h5);
			rd(ADDR_ACC1);
			chk("shift", shx(k, a), rv);
			if (k == 1) chk("chain so", 8'(a[6]), 8'(chain_so));
		end
		// crc steps at several top bits, polynomial from d0
		crc_en = 1'b1;
		cfg(3'h6, mk(OP_PASS, SH_LEFT, 1'b0, DST_A1, 2'h0));
		for (k = 0; k < 4; k++) begin
			msb_sel = 3'(2 * k + 1);
			a = 8'($urandom);
			d = 8'($urandom);
			wr(ADDR_ACC0, a);
			wr(ADDR_OPR0, d);
			run(3'h6);
			rd(ADDR_ACC1);
			chk("crc", crc(a, d, msb_sel), rv);
		end
		crc_en = 1'b0;
		msb_sel = TOP_BIT;
		a = 8'($urandom % 254) + 8'h01;
		wr(ADDR_ACC0, a);
		wr(ADDR_OPR0, a);
		chk("eq0", 8'h01, 8'(route_out[0]));
		chk("chain eq", 8'(chain_eq_in), 8'(route_out[5]));
		chk("chain eq out", 8'h01, 8'(chain_eq_out));
		chk("a0 zero", 8'h00, 8'(route_out[1]));
		wr(ADDR_ACC0, ALL_ONES);
		chk("a0 ones", 8'h01, 8'(route_out[2]));
		wr(ADDR_ACC0, RST_BYTE);
		chk("a0 zero", 8'h01, 8'(route_out[1]));
		// queue 0 fed by the bus into d0, queue 1 captures a1 for the bus
		q_dir = 2'b10;
		q_acc_sel = 2'b10;
		for (k = 0; k < 4; k++) begin
			qv[k] = 8'($urandom);
			chk("wr ready", 8'h01, 8'(q_wr_ready[0]));
			wr(ADDR_QUE0, qv[k]);
		end
		chk("wr ready", 8'h00, 8'(q_wr_ready[0]));
		chk("q0 full", 8'h01, 8'(route_out[4]));
		wr(ADDR_QUE0, ~qv[0]);
		cfg(3'h1, mk(OP_PASS, SH_NONE, 1'b0, 2'h0, 2'h1));
		for (k = 0; k < 5; k++) begin
			run(3'h1);
			rd(ADDR_OPR0);
			chk("q0 load", qv[k < 4 ? k : 3], rv);
		end
		chk("q0 empty", 8'h01, 8'(route_out[3]));
		cfg(3'h2, mk(OP_PASS, SH_NONE, 1'b0, 2'h0, 2'h2));
		for (k = 0; k < 2; k++) begin
			wr(ADDR_ACC1, qv[k] ^ 8'h5A);
			run(3'h2);
		end
		for (k = 0; k < 2; k++) begin
			rd(ADDR_QUE1);
			chk("q1 out", qv[k] ^ 8'h5A, rv);
		end
		for (n = 0; n < 8; n++) begin
			k = $urandom % 12;
			pin = 12'($urandom);
			tsel = n[0] ? '0 : 96'(1) << k;
			csel = n[0] ? 96'(1) << k : '0;
			#1 chk("pld comb", 8'(pin[k] ^ n[0]), 8'(pld0_out[0]));
			@(posedge ref_clk);
			#1 chk("pld reg", 8'(pin[k] ^ n[0]), 8'(pld1_out[0]));
		end
		end_sim();
	end
endmodule
`default_nettype wire
